/* File: src/fsps_sequencer.sv */
// flash self-programming sequencer with wishbone register slave
// assumes the cpu raises the instruction strobes through register writes,
// fuse and lock values as static inputs, eeprom busy from same clock
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - load pattern plus store writes data pair into buffer slot
// - erase ignores the data pair and pointer bits outside page field
// - cpu is stalled for whole erase and write
// - buffer slot comes from the word-in-page index field
// - buffer clears after page write, on clear bit, and on reset
// - eeprom write during page loading discards loaded buffer data
// - load instruction compares the whole pointer to pick the fuse or lock byte
// - upper three control bits always read zero
// - load within three cycles of fuse arm returns fuse or lock byte
// - write bit clears at completion or when window expires
// - erase bit clears at completion or when window expires
// - enable opens four-cycle store window, clears after store or expiry
// - enable reads one throughout erase and write
// - enable alone makes store write data pair, pointer lsb ignored
// - undefined command patterns have no effect
// - clear bit while filling empties the buffer
// - pointer one lock, zero fuse low, three fuse high
// - eeprom write blocks programming and fuse reads
// - operation stall lasts between min and max programming time
module fsps_sequencer #(
  parameter int unsigned PROG_CYC = fsps_pkg::PROG_MIN_CYC
) (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        eeprom_busy,
  input  wire logic [7:0]  lock_bits,
  input  wire logic [7:0]  fuse_low,
  input  wire logic [7:0]  fuse_high,
  output logic             cpu_stall,
  output logic             flash_erase,
  output logic             flash_write,
  output logic [5:0]       flash_page
);
  fsps_buf_if bif ();
  fsps_page_buf u_buf (
    .clk    (clk),
    .arst_n (arst_n),
    .bus    (bif.buf_side)
  );

  fsps_pkg::fsps_state_e state;
  logic [4:0]  ctrl;
  logic [2:0]  win;
  logic [15:0] pointer;
  logic [15:0] data_pair;
  logic [7:0]  load_result;
  logic [22:0] busy_cnt;
  logic        clear_wr;
  logic        store_go;
  logic        load_go;
  logic        wr_access;
  logic        op_done;

  // decode a byte address against a register offset
  function automatic logic hit(input logic [3:0] adr, input logic [3:0] off);
    return adr == off;
  endfunction

  /////////////////////////////////////////////////////////////////////////
  // bus slave: one wait-free ack cycle after the request is seen
  assign wr_access = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
  assign store_go  = wr_access & hit(wb_adr_i, fsps_pkg::OFF_INSTR)
                     & wb_dat_i[fsps_pkg::BIT_INSTR_STORE];
  assign load_go   = wr_access & hit(wb_adr_i, fsps_pkg::OFF_INSTR)
                     & wb_dat_i[fsps_pkg::BIT_INSTR_LOAD];
  assign clear_wr  = wr_access & hit(wb_adr_i, fsps_pkg::OFF_CTRL)
                     & (wb_dat_i[4:0] == fsps_pkg::CMD_CLEAR) & ~eeprom_busy
                     & (state != fsps_pkg::FSPS_BUSY);
  assign op_done   = (state == fsps_pkg::FSPS_BUSY) && (busy_cnt == 23'h000001);

  // ack pulse
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i & wb_stb_i & ~wb_ack_o;
    end
  end

  // read data mux, unmapped reads give zero
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wb_dat_o <= 32'h00000000;
    end else if (wb_cyc_i & wb_stb_i & ~wb_we_i & ~wb_ack_o) begin
      if (hit(wb_adr_i, fsps_pkg::OFF_CTRL)) begin
        wb_dat_o <= {27'h0000000, ctrl};
      end else if (hit(wb_adr_i, fsps_pkg::OFF_POINTER)) begin
        wb_dat_o <= {16'h0000, pointer};
      end else if (hit(wb_adr_i, fsps_pkg::OFF_DATA)) begin
        wb_dat_o <= {16'h0000, data_pair};
      end else if (hit(wb_adr_i, fsps_pkg::OFF_INSTR)) begin
        wb_dat_o <= {24'h000000, load_result};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // pointer and data pair registers
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pointer   <= 16'h0000;
      data_pair <= 16'h0000;
    end else if (wr_access) begin
      if (hit(wb_adr_i, fsps_pkg::OFF_POINTER)) begin
        pointer <= wb_dat_i[15:0];
      end
      if (hit(wb_adr_i, fsps_pkg::OFF_DATA)) begin
        data_pair <= wb_dat_i[15:0];
      end
    end
  end

  /////////////////////////////////////////////////////////////////////////
  // control register, arming window and operation sequencing
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= fsps_pkg::FSPS_IDLE;
      ctrl  <= fsps_pkg::CTRL_RESET[4:0];
      win   <= 3'h0;
    end else begin
      case (state)
        fsps_pkg::FSPS_IDLE: begin
          if (wr_access && hit(wb_adr_i, fsps_pkg::OFF_CTRL) && !eeprom_busy) begin
            if (wb_dat_i[4:0] == fsps_pkg::CMD_LOAD || wb_dat_i[4:0] == fsps_pkg::CMD_ERASE
                || wb_dat_i[4:0] == fsps_pkg::CMD_WRITE
                || wb_dat_i[4:0] == fsps_pkg::CMD_FUSE) begin
              ctrl  <= wb_dat_i[4:0];
              win   <= (wb_dat_i[4:0] == fsps_pkg::CMD_FUSE) ?
                       fsps_pkg::LOAD_WIN : fsps_pkg::STORE_WIN;
              state <= fsps_pkg::FSPS_ARMED;
            end
          end
        end
        fsps_pkg::FSPS_ARMED: begin
          if (store_go && (ctrl == fsps_pkg::CMD_ERASE || ctrl == fsps_pkg::CMD_WRITE)) begin
            state <= fsps_pkg::FSPS_BUSY;
          end else if (store_go || load_go || win == 3'h1) begin
            ctrl  <= 5'h00;
            state <= fsps_pkg::FSPS_IDLE;
          end else begin
            win <= win - 3'h1;
          end
        end
        fsps_pkg::FSPS_BUSY: begin
          if (op_done) begin
            ctrl  <= 5'h00;
            state <= fsps_pkg::FSPS_IDLE;
          end
        end
        default: state <= fsps_pkg::FSPS_IDLE;
      endcase
    end
  end

  // busy counter sets the stall length
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      busy_cnt <= 23'h000000;
    end else if (state == fsps_pkg::FSPS_ARMED && store_go) begin
      busy_cnt <= PROG_CYC[22:0];
    end else if (busy_cnt != 23'h000000) begin
      busy_cnt <= busy_cnt - 23'h000001;
    end
  end

  // flash strobes and page latch, outputs from flops
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cpu_stall   <= 1'b0;
      flash_erase <= 1'b0;
      flash_write <= 1'b0;
      flash_page  <= 6'h00;
    end else begin
      if (state == fsps_pkg::FSPS_ARMED && store_go && ctrl == fsps_pkg::CMD_ERASE) begin
        flash_erase <= 1'b1;
        cpu_stall   <= 1'b1;
        flash_page  <= pointer[15:10];
      end else if (state == fsps_pkg::FSPS_ARMED && store_go
                   && ctrl == fsps_pkg::CMD_WRITE) begin
        flash_write <= 1'b1;
        cpu_stall   <= 1'b1;
        flash_page  <= pointer[15:10];
      end else if (op_done) begin
        flash_erase <= 1'b0;
        flash_write <= 1'b0;
        cpu_stall   <= 1'b0;
      end
    end
  end

  // fuse and lock readback into the load result
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      load_result <= 8'h00;
    end else if (load_go && state == fsps_pkg::FSPS_ARMED && ctrl == fsps_pkg::CMD_FUSE) begin
      if (pointer == fsps_pkg::PTR_LOCK) begin
        load_result <= lock_bits;
      end else if (pointer == fsps_pkg::PTR_FUSE_HI) begin
        load_result <= fuse_high;
      end else begin
        load_result <= fuse_low;
      end
    end
  end

  // buffer port: store with enable alone loads the data pair
  assign bif.wr    = store_go && state == fsps_pkg::FSPS_ARMED
                     && ctrl == fsps_pkg::CMD_LOAD;
  assign bif.idx   = pointer[fsps_pkg::WORD_BITS:1];
  assign bif.wdata = data_pair;
  assign bif.clr   = clear_wr || (op_done && flash_write)
                     || (eeprom_busy && bif.loaded);

  /////////////////////////////////////////////////////////////////////////
  // checks
  a_stall_on_erase: assert property (@(posedge clk) disable iff (!arst_n)
    (state == fsps_pkg::FSPS_ARMED && store_go && ctrl == fsps_pkg::CMD_ERASE)
    |=> cpu_stall) else $error("no stall on erase");
  a_enable_held: assert property (@(posedge clk) disable iff (!arst_n)
    cpu_stall |-> ctrl[fsps_pkg::BIT_ENABLE]) else $error("enable dropped in op");
  a_window_ends: assert property (@(posedge clk) disable iff (!arst_n)
    (state == fsps_pkg::FSPS_IDLE ##1 state == fsps_pkg::FSPS_ARMED
     && ctrl == fsps_pkg::CMD_LOAD) ##1 !store_go [*4]
    |=> ctrl == 5'h00) else $error("window did not expire");
  a_reserved_zero: assert property (@(posedge clk) disable iff (!arst_n)
    wb_ack_o && $past(hit(wb_adr_i, fsps_pkg::OFF_CTRL) && !wb_we_i)
    |-> wb_dat_o[7:5] == 3'h0) else $error("reserved bits set");
  a_bad_cmd_ignored: assert property (@(posedge clk) disable iff (!arst_n)
    (state == fsps_pkg::FSPS_IDLE && wr_access && hit(wb_adr_i, fsps_pkg::OFF_CTRL)
     && wb_dat_i[4:0] == 5'h07) |=> state == fsps_pkg::FSPS_IDLE)
    else $error("bad pattern acted");
  a_eeprom_blocks: assert property (@(posedge clk) disable iff (!arst_n)
    (state == fsps_pkg::FSPS_IDLE && eeprom_busy) |=> state != fsps_pkg::FSPS_ARMED)
    else $error("armed during eeprom write");
  a_stall_length: assert property (@(posedge clk) disable iff (!arst_n)
    $rose(cpu_stall) |-> cpu_stall [*8]) else $error("stall too short");
  a_write_clears: assert property (@(posedge clk) disable iff (!arst_n)
    (op_done && flash_write) |=> !bif.loaded) else $error("buffer kept");
  c_erase: cover property (@(posedge clk) disable iff (!arst_n) $fell(flash_erase));
  c_write: cover property (@(posedge clk) disable iff (!arst_n) $fell(flash_write));
  c_load: cover property (@(posedge clk) disable iff (!arst_n) bif.wr);
  c_fuse: cover property (@(posedge clk) disable iff (!arst_n)
    load_go && ctrl == fsps_pkg::CMD_FUSE);
endmodule
`default_nettype wire

/* File: inc/fsps_pkg.sv */
// package for the flash self-programming sequencer
// assumes a 20 MHz system clock and a classic wishbone register bus
package fsps_pkg;
  // clock rate and programming times
  localparam int unsigned CLK_HZ         = 20000000;
  localparam int unsigned PROG_MIN_US    = 3700;
  localparam int unsigned PROG_MAX_US    = 4500;
  localparam int unsigned PROG_MIN_CYC   = (PROG_MIN_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned PROG_MAX_CYC   = (PROG_MAX_US * (CLK_HZ / 1000)) / 1000;
  // arming windows in cycles
  localparam logic [2:0]  STORE_WIN      = 3'h4;
  localparam logic [2:0]  LOAD_WIN       = 3'h3;
  // register byte offsets
  localparam logic [3:0]  OFF_CTRL       = 4'h0;
  localparam logic [3:0]  OFF_POINTER    = 4'h4;
  localparam logic [3:0]  OFF_DATA       = 4'h8;
  localparam logic [3:0]  OFF_INSTR      = 4'hc;
  // control field positions
  localparam int unsigned BIT_ENABLE     = 0;
  localparam int unsigned BIT_ERASE      = 1;
  localparam int unsigned BIT_WRITE      = 2;
  localparam int unsigned BIT_FUSE       = 3;
  localparam int unsigned BIT_CLEAR      = 4;
  localparam logic [7:0]  CTRL_RESET     = 8'h00;
  // command patterns in the lower five control bits
  localparam logic [4:0]  CMD_LOAD       = 5'h01;
  localparam logic [4:0]  CMD_ERASE      = 5'h03;
  localparam logic [4:0]  CMD_WRITE      = 5'h05;
  localparam logic [4:0]  CMD_FUSE       = 5'h09;
  localparam logic [4:0]  CMD_CLEAR      = 5'h11;
  // instruction register command bit positions
  localparam int unsigned BIT_INSTR_STORE = 0;
  localparam int unsigned BIT_INSTR_LOAD  = 1;
  // pointer layout: byte bit, word index, page select
  localparam int unsigned WORD_BITS      = 4;
  localparam int unsigned PAGE_BITS      = 6;
  localparam int unsigned WORDS          = 16;
  localparam logic [15:0] PTR_LOCK       = 16'h0001;
  localparam logic [15:0] PTR_FUSE_LO    = 16'h0000;
  localparam logic [15:0] PTR_FUSE_HI    = 16'h0003;
  typedef enum logic [1:0] {FSPS_IDLE, FSPS_ARMED, FSPS_BUSY} fsps_state_e;
endpackage

/* File: inc/fsps_buf_if.sv */
// interface between sequencer and its page buffer
// assumes one clock domain
`timescale 1ns/100ps
`default_nettype none
interface fsps_buf_if;
  logic        wr;
  logic        clr;
  logic [3:0]  idx;
  logic [15:0] wdata;
  logic        loaded;
  modport seq (output wr, output clr, output idx, output wdata, input loaded);
  modport buf_side (input wr, input clr, input idx, input wdata, output loaded);
endinterface
`default_nettype wire

/* File: src/fsps_page_buf.sv */
// temporary page buffer of one flash page
// assumes clk, arst_n shared with the sequencer
`timescale 1ns/100ps
`default_nettype none
module fsps_page_buf (
  input  wire logic   clk,
  input  wire logic   arst_n,
  fsps_buf_if.buf_side bus
);
  logic [15:0] mem [fsps_pkg::WORDS];
  logic [fsps_pkg::WORDS-1:0] valid;

  // buffer words; contents only meaningful where valid
  always_ff @(posedge clk) begin
    if (bus.wr) begin
      mem[bus.idx] <= bus.wdata;
    end
  end

  // valid marks, wiped on clear and reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid <= '0;
    end else if (bus.clr) begin
      valid <= '0;
    end else if (bus.wr) begin
      valid[bus.idx] <= 1'b1;
    end
  end

  assign bus.loaded = |valid;
endmodule
`default_nettype wire

/* File: verif/fsps_cpu_model.sv */
// cpu core model: classic wishbone master issuing register cycles
// assumes one clock, requests are issued one at a time by the bench
`timescale 1ns/100ps
`default_nettype none
module fsps_cpu_model (
  input  wire logic        clk,
  input  wire logic        ack,
  output logic             cyc,
  output logic             stb,
  output logic             we,
  output logic [3:0]       adr,
  output logic [3:0]       sel,
  output logic [31:0]      dat,
  output logic             hang
);
  initial begin
    cyc  = 1'b0;
    stb  = 1'b0;
    we   = 1'b0;
    adr  = 4'h0;
    sel  = 4'h0;
    dat  = 32'h0;
    hang = 1'b0;
  end
  // one classic cycle, held until ack, released lines show inverted values
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    sel <= 4'hf;
    dat <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) hang <= 1'b1;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= ~w;
    adr <= ~a;
    sel <= 4'h0;
    dat <= ~d;
  endtask
endmodule
`default_nettype wire

/* File: verif/tb_flash_self_programming_sequencer.sv */
// testbench for the flash self-programming sequencer
// assumes the sequencer answers every cycle and a shortened busy count
`timescale 1ns/100ps
`default_nettype none
module tb_flash_self_programming_sequencer;
  localparam int unsigned PROG = 20;
  logic        clk, arst_n, eeprom_busy, ack, cyc, stb, we, hang, stall, ers, wrt;
  logic [3:0]  adr, sel;
  logic [31:0] dat_i, dat_o, scnt;
  logic [7:0]  fb [3];
  logic [5:0]  page;
  logic [31:0] exp_q [$];
  int          bad_count, total_checks;
  logic        bench_hang = 1'b0; // stall wait ran out, kept apart from the model's hang
  fsps_cpu_model fsps_cpu_model_i (.clk(clk), .ack(ack), .cyc(cyc), .stb(stb), .we(we),
    .adr(adr), .sel(sel), .dat(dat_i), .hang(hang));
  fsps_sequencer #(.PROG_CYC(PROG)) fsps_sequencer_i (.clk(clk), .arst_n(arst_n),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(dat_i), .wb_dat_o(dat_o), .wb_ack_o(ack), .eeprom_busy(eeprom_busy),
    .lock_bits(fb[0]), .fuse_low(fb[1]), .fuse_high(fb[2]), .cpu_stall(stall),
    .flash_erase(ers), .flash_write(wrt), .flash_page(page));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic final_report();
    if (bad_count == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    fsps_cpu_model_i.xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    fsps_cpu_model_i.xfer(1'b0, a, 32'h0);
  endtask
  // arm, store, then follow the stall to its end
  task automatic run_op(input logic [4:0] cmd, input logic [15:0] ptr);
    int n;
    wr(fsps_pkg::OFF_POINTER, {16'h0, ptr});
    wr(fsps_pkg::OFF_DATA, $urandom);
    wr(fsps_pkg::OFF_CTRL, {27'h0, cmd});
    wr(fsps_pkg::OFF_INSTR, 32'h1);
    check({31'h0, stall}, 32'h1);
    check({26'h0, page}, {26'h0, ptr[15:10]});
    check({30'h0, ers, wrt}, {30'h0, cmd == fsps_pkg::CMD_ERASE, cmd == fsps_pkg::CMD_WRITE});
    rd(fsps_pkg::OFF_CTRL, {27'h0, cmd});
    n = 0;
    while (stall === 1'b1 && n < PROG + 20) begin
      @(posedge clk);
      n++;
    end
    if (n >= PROG + 20) bench_hang = 1'b1;
    rd(fsps_pkg::OFF_CTRL, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // clock
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // read results against the oldest note
  always @(posedge clk) begin
    if (ack === 1'b1 && we === 1'b0) begin
      if (exp_q.size() == 0) check(dat_o, 32'hdead_beef);
      else check(dat_o, exp_q.pop_front());
    end
  end
  // stall length in cycles
  always @(posedge clk) begin
    if (stall === 1'b1) scnt <= scnt + 32'h1;
    else if (scnt != 32'h0) begin
      check(scnt, PROG);
      scnt <= 32'h0;
    end
  end
  // hang cut
  always @(posedge clk) begin
    if (hang === 1'b1 || bench_hang === 1'b1) begin
      bad_count++;
      final_report();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [4:0] und [4];
    logic [15:0] fp [3];
    logic [5:0] p;
    und = '{5'h07, 5'h0b, 5'h15, 5'h1f};
    fp = '{fsps_pkg::PTR_LOCK, fsps_pkg::PTR_FUSE_LO, fsps_pkg::PTR_FUSE_HI};
    arst_n = 1'b0;
    eeprom_busy = 1'b0;
    scnt = 32'h0;
    void'($urandom(13947));
    for (int i = 0; i < 3; i++) fb[i] = 8'($urandom);
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    rd(fsps_pkg::OFF_CTRL, 32'h0);
    wr(fsps_pkg::OFF_CTRL, 32'he1);
    rd(fsps_pkg::OFF_CTRL, 32'h01);
    for (int i = 0; i < 2; i++) begin
      wr(fsps_pkg::OFF_CTRL, {27'h0, i ? fsps_pkg::CMD_WRITE : fsps_pkg::CMD_ERASE});
      repeat (6) @(posedge clk);
      rd(fsps_pkg::OFF_CTRL, 32'h0);
    end
    foreach (und[i]) begin
      wr(fsps_pkg::OFF_CTRL, {27'h0, und[i]});
      rd(fsps_pkg::OFF_CTRL, 32'h0);
    end
    eeprom_busy <= 1'b1;
    wr(fsps_pkg::OFF_CTRL, {27'h0, fsps_pkg::CMD_ERASE});
    rd(fsps_pkg::OFF_CTRL, 32'h0);
    eeprom_busy <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wr(fsps_pkg::OFF_POINTER, {16'h0, 12'h0, 3'(i), 1'($urandom)});
      wr(fsps_pkg::OFF_DATA, $urandom);
      wr(fsps_pkg::OFF_CTRL, {27'h0, fsps_pkg::CMD_LOAD});
      wr(fsps_pkg::OFF_INSTR, 32'h1);
      rd(fsps_pkg::OFF_CTRL, 32'h0);
    end
    check({31'h0, fsps_sequencer_i.bif.loaded}, 32'h1);
    wr(fsps_pkg::OFF_CTRL, {27'h0, fsps_pkg::CMD_CLEAR});
    rd(fsps_pkg::OFF_CTRL, 32'h0);
    check({31'h0, fsps_sequencer_i.bif.loaded}, 32'h0);
    p = 6'($urandom);
    run_op(fsps_pkg::CMD_ERASE, {p, 10'($urandom)});
    run_op(fsps_pkg::CMD_WRITE, {p, 10'h0});
    foreach (fp[i]) begin
      wr(fsps_pkg::OFF_POINTER, {16'h0, fp[i]});
      wr(fsps_pkg::OFF_CTRL, {27'h0, fsps_pkg::CMD_FUSE});
      wr(fsps_pkg::OFF_INSTR, 32'h2);
      rd(fsps_pkg::OFF_INSTR, {24'h0, fb[i]});
    end
    wr(fsps_pkg::OFF_CTRL, {27'h0, fsps_pkg::CMD_ERASE});
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    rd(fsps_pkg::OFF_CTRL, 32'h0);
    repeat (4) @(posedge clk);
    check(32'(exp_q.size()), 32'h0);
    final_report();
  end
endmodule
`default_nettype wire
